// >>> hdl/tws_consts.svh
// constants for the two-wire control port slave
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// fixed upper six bits of the 7-bit slave address
`define TWS_ADDR_UPPER 6'h26
// highest register pointer that is accepted and reached
`define TWS_PTR_MAX 8'h2E
// pointer after reset
`define TWS_PTR_RESET 8'h00
// bits in one byte on the wire
`define TWS_BYTE_BITS 4'h8
// synchroniser bit positions
`define TWS_SYNC_SCL 0
`define TWS_SYNC_SDA 1
`define TWS_SYNC_ASEL 2

`endif

// >>> hdl/tws_pkg.sv
// types for the two-wire control port slave
package tws_pkg;

    // transfer phase of the slave
    typedef enum logic [2:0] {
        TWS_IDLE   = 3'b000,
        TWS_ADDR   = 3'b001,
        TWS_PTR    = 3'b010,
        TWS_WDATA  = 3'b011,
        TWS_RDATA  = 3'b100,
        TWS_IGNORE = 3'b101
    } tws_state_t;

endpackage

// >>> hdl/tws_sync.sv
// two-flop synchronisers with a third stage kept for edge detection
`timescale 1ns/1ps

module tws_sync (
    input wire logic clk_i,             // system clock
    input wire logic reset_n_i,         // synchronous reset, active low
    input wire logic [2:0] async_i,     // raw pin levels
    output logic [2:0] level_o,         // synchronised levels
    output logic [2:0] prev_o           // levels one cycle older
);

    // ==========================================================
    // per-bit chain
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_bit
            logic meta;
            logic stable;
            logic older;
            // pins idle high, so reset to one to avoid a fake start
            always_ff @(posedge clk_i) begin
                if (!reset_n_i) begin
                    meta <= 1'b1;
                    stable <= 1'b1;
                    older <= 1'b1;
                end else begin
                    meta <= async_i[g];
                    stable <= meta;
                    older <= stable;
                end
            end
            assign level_o[g] = stable;
            assign prev_o[g] = older;
        end
    endgenerate

endmodule

// >>> hdl/tws_slave.sv
// two-wire serial control port slave with register pointer
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_slave (
    input wire logic clk_i,                 // system clock, 100 MHz
    input wire logic reset_n_i,             // synchronous reset, active low
    input wire logic scl_i,                 // serial clock from master
    input wire logic sda_i,                 // serial data line level
    output logic sda_o,                     // data drive value, always low
    output logic sda_oe_o,                  // high while pulling data low
    input wire logic address_select_pin_i,  // address lsb strap
    output logic [7:0] reg_addr_o,          // register pointer
    output logic [7:0] reg_wdata_o,         // byte to write
    output logic reg_wr_o,                  // write strobe, one cycle
    output logic reg_rd_o,                  // read strobe, one cycle
    input wire logic [7:0] reg_rdata_i      // register contents at reg_addr_o
);

    // ==========================================================
    // synchronised pins and bus conditions
    logic [2:0] level;
    logic [2:0] prev;

    tws_sync u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i({address_select_pin_i, sda_i, scl_i}),
        .level_o(level),
        .prev_o(prev)
    );

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // both lines pass the same delay, so their order is kept
    assign scl = level[`TWS_SYNC_SCL];
    assign sda = level[`TWS_SYNC_SDA];
    assign scl_rise = scl & ~prev[`TWS_SYNC_SCL];
    assign scl_fall = ~scl & prev[`TWS_SYNC_SCL];
    // data edges with clock high are conditions, not bits
    assign start_seen = scl & prev[`TWS_SYNC_SCL] & prev[`TWS_SYNC_SDA] & ~sda;
    assign stop_seen = scl & prev[`TWS_SYNC_SCL] & ~prev[`TWS_SYNC_SDA] & sda;

    // saturating pointer step shared by reads and writes
    function automatic logic [7:0] ptr_step(input logic [7:0] p);
        if (p >= `TWS_PTR_MAX) begin
            ptr_step = `TWS_PTR_MAX;
        end else begin
            ptr_step = p + 8'h01;
        end
    endfunction

    // ==========================================================
    // transfer state
    tws_pkg::tws_state_t state;
    tws_pkg::tws_state_t next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic ack_phase;
    logic next_ack_phase;
    logic ack_ok;
    logic next_ack_ok;
    logic read_dir;
    logic next_read_dir;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic drive;
    logic next_drive;
    logic [7:0] wdata;
    logic [7:0] next_wdata;
    logic wr;
    logic next_wr;
    logic rd;
    logic next_rd;

    // next-state logic; start and stop override everything
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_ack_phase = ack_phase;
        next_ack_ok = ack_ok;
        next_read_dir = read_dir;
        next_shreg = shreg;
        next_ptr = ptr;
        next_drive = drive;
        next_wdata = wdata;
        next_wr = 1'b0;
        next_rd = 1'b0;
        if (start_seen) begin
            // also a repeated start from any state
            next_state = tws_pkg::TWS_ADDR;
            next_bit_cnt = 4'h0;
            next_ack_phase = 1'b0;
            next_drive = 1'b0;
        end else if (stop_seen) begin
            next_state = tws_pkg::TWS_IDLE;
            next_drive = 1'b0;
        end else begin
            unique case (state)
                tws_pkg::TWS_IDLE, tws_pkg::TWS_IGNORE: begin
                    next_drive = 1'b0;
                end
                tws_pkg::TWS_ADDR, tws_pkg::TWS_PTR, tws_pkg::TWS_WDATA: begin
                    if (!ack_phase && scl_rise && bit_cnt != `TWS_BYTE_BITS) begin
                        next_shreg = {shreg[6:0], sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (!ack_phase && scl_fall && bit_cnt == `TWS_BYTE_BITS) begin
                        // decide the acknowledge once all eight bits are in
                        next_ack_phase = 1'b1;
                        if (state == tws_pkg::TWS_ADDR) begin
                            next_ack_ok = (shreg[7:1] ==
                                {`TWS_ADDR_UPPER, level[`TWS_SYNC_ASEL]});
                            next_read_dir = shreg[0];
                        end else if (state == tws_pkg::TWS_PTR) begin
                            next_ack_ok = (shreg <= `TWS_PTR_MAX);
                            if (shreg <= `TWS_PTR_MAX) begin
                                next_ptr = shreg;
                            end
                        end else begin
                            next_ack_ok = 1'b1;
                            next_wdata = shreg;
                            next_wr = 1'b1;
                        end
                        next_drive = next_ack_ok;
                    end else if (ack_phase && scl_fall) begin
                        // ninth pulse over: release and move on
                        next_ack_phase = 1'b0;
                        next_bit_cnt = 4'h0;
                        next_drive = 1'b0;
                        if (!ack_ok) begin
                            next_state = tws_pkg::TWS_IGNORE;
                        end else if (state == tws_pkg::TWS_ADDR && read_dir) begin
                            // read begins at the stored pointer
                            next_state = tws_pkg::TWS_RDATA;
                            next_shreg = reg_rdata_i;
                            next_rd = 1'b1;
                            next_drive = ~reg_rdata_i[7];
                        end else if (state == tws_pkg::TWS_ADDR) begin
                            next_state = tws_pkg::TWS_PTR;
                        end else if (state == tws_pkg::TWS_PTR) begin
                            next_state = tws_pkg::TWS_WDATA;
                        end else begin
                            next_ptr = ptr_step(ptr);
                        end
                    end
                end
                tws_pkg::TWS_RDATA: begin
                    if (!ack_phase && scl_fall) begin
                        if (bit_cnt == `TWS_BYTE_BITS - 4'h1) begin
                            // byte sent: release for the master acknowledge
                            next_ack_phase = 1'b1;
                            next_drive = 1'b0;
                            next_ptr = ptr_step(ptr);
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_drive = ~shreg[6];
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end else if (ack_phase && scl_rise) begin
                        next_ack_ok = ~sda;
                    end else if (ack_phase && scl_fall) begin
                        next_ack_phase = 1'b0;
                        next_bit_cnt = 4'h0;
                        if (!ack_ok) begin
                            // no acknowledge: end of data, line stays released
                            next_state = tws_pkg::TWS_IGNORE;
                            next_drive = 1'b0;
                        end else begin
                            next_shreg = reg_rdata_i;
                            next_rd = 1'b1;
                            next_drive = ~reg_rdata_i[7];
                        end
                    end
                end
                default: begin
                    next_state = tws_pkg::TWS_IDLE;
                    next_drive = 1'b0;
                end
            endcase
        end
    end

    // registers only
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state <= tws_pkg::TWS_IDLE;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            ack_ok <= 1'b0;
            read_dir <= 1'b0;
            shreg <= 8'h00;
            ptr <= `TWS_PTR_RESET;
            drive <= 1'b0;
            wdata <= 8'h00;
            wr <= 1'b0;
            rd <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            ack_phase <= next_ack_phase;
            ack_ok <= next_ack_ok;
            read_dir <= next_read_dir;
            shreg <= next_shreg;
            ptr <= next_ptr;
            drive <= next_drive;
            wdata <= next_wdata;
            wr <= next_wr;
            rd <= next_rd;
        end
    end

    // ==========================================================
    // outputs
    assign sda_o = 1'b0;
    assign sda_oe_o = drive;
    assign reg_addr_o = ptr;
    assign reg_wdata_o = wdata;
    assign reg_wr_o = wr;
    assign reg_rd_o = rd;

endmodule

// >>> tb/tws_slave_chk.sv
// assertion checker for the two-wire control port slave
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_slave_chk (
    input wire logic clk_i, // system clock
    input wire logic reset_n_i, // sync reset, low
    input wire logic scl_i, // serial clock
    input wire logic sda_i, // data wire
    input wire logic sda_o, // drive value
    input wire logic sda_oe_o, // pull enable
    input wire logic address_select_pin_i, // strap
    input wire logic [7:0] reg_addr_o, // pointer
    input wire logic [7:0] reg_wdata_o, // write byte
    input wire logic reg_wr_o, // write strobe
    input wire logic reg_rd_o, // read strobe
    input wire logic [7:0] reg_rdata_i // read byte
);
    // ==========
    // expected pointer once the current byte is done, saturating at the top
    logic [7:0] step;
    logic [7:0] next_step;
    always_comb begin
        next_step = step;
        if (reg_wr_o || reg_rd_o) begin
            next_step = (reg_addr_o == `TWS_PTR_MAX) ? reg_addr_o : reg_addr_o + 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        step <= reset_n_i ? next_step : 8'h00;
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // pointer holds for eight cycles after a strobe
    sequence s_hold;
        $stable(reg_addr_o)[*8];
    endsequence
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive moved with clock high");
    AST_ACK_HOLD: assert property ($rose(sda_oe_o) |-> sda_oe_o[*8])
        else $error("data pull too short");
    AST_WR_ACKED: assert property (reg_wr_o |-> sda_oe_o && !scl_i)
        else $error("write byte not acknowledged");
    AST_WR_PULSE: assert property (reg_wr_o |=> !reg_wr_o)
        else $error("write strobe too long");
    AST_RD_PULSE: assert property (reg_rd_o |=> !reg_rd_o)
        else $error("read strobe too long");
    AST_PTR_MAX: assert property (reg_addr_o <= `TWS_PTR_MAX)
        else $error("pointer above top");
    AST_WR_STEP: assert property (reg_wr_o |=> s_hold ##[1:20] (reg_addr_o == step))
        else $error("pointer not stepped after write");
    AST_RD_STEP: assert property (reg_rd_o |=> s_hold ##[100:140] (reg_addr_o == step))
        else $error("pointer not stepped after read");
    AST_RD_MSB: assert property (reg_rd_o |-> (sda_oe_o == !reg_rdata_i[7]))
        else $error("first read bit not msb");
    AST_SDA_LOW: assert property (sda_oe_o |-> !sda_o)
        else $error("data drive value not low");
endmodule

bind tws_slave tws_slave_chk chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .address_select_pin_i(address_select_pin_i), .reg_addr_o(reg_addr_o),
    .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
    .reg_rdata_i(reg_rdata_i));

// >>> tb/tws_host_model.sv
// behavioural two-wire bus master on the far side
`timescale 1ns/1ps

module tws_host_model (
    output logic scl_o, // serial clock
    output logic sda_o, // data drive, 1 releases
    input wire logic sda_i // resolved data wire
);
    // ==========
    // bus idles high; clock stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // start and repeated start alike
    task automatic start();
        sda_o = 1'b1;
        #40 scl_o = 1'b1;
        #80 sda_o = 1'b0;
        #80 scl_o = 1'b0;
        #40;
    endtask
    task automatic stop();
        sda_o = 1'b0;
        #40 scl_o = 1'b1;
        #80 sda_o = 1'b1;
        #80;
    endtask
    // data moves only 40 ns after the clock falls, well clear of the high phase
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_o = d[i];
            #40 scl_o = 1'b1;
            #80 scl_o = 1'b0;
            #40;
        end
        sda_o = 1'b1;
        #40 scl_o = 1'b1;
        #40 ack = sda_i;
        #40 scl_o = 1'b0;
        #40;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        sda_o = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            #40 scl_o = 1'b1;
            #40 d[i] = sda_i;
            #40 scl_o = 1'b0;
            #40;
        end
        sda_o = !ack;
        #40 scl_o = 1'b1;
        #80 scl_o = 1'b0;
        // leave the line to the next step, so a following stop sets it once
        #40;
    endtask
endmodule

// >>> tb/tws_slave_tb_top.sv
// self-checking bench for the two-wire control port slave
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("Error %0t got %h exp %h", $time, a, e); end end

module tws_slave_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic strap = 1'b0;
    logic scl;
    logic m_sda;
    logic oe;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wd;
    logic [7:0] mem [0:255];
    logic [7:0] wq_a[$];
    logic [7:0] wq_d[$];
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int rd_cnt = 0;
    // open-drain wire with pull-up
    wire sda = m_sda & ~oe;
    tws_slave uut (.clk_i(clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(oe), .address_select_pin_i(strap), .reg_addr_o(addr), .reg_wdata_o(wd),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(mem[addr]));
    tws_host_model host (.scl_o(scl), .sda_o(m_sda), .sda_i(sda));
    initial begin
        forever #5 clk = ~clk;
    end
    // log register strobes at the falling edge, where they have settled
    always @(negedge clk) begin
        cycles++;
        if (wr === 1'b1) begin
            wq_a.push_back(addr);
            wq_d.push_back(wd);
        end
        if (rd === 1'b1) begin
            rd_cnt++;
        end
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wb(input logic [7:0] d, input logic e);
        logic a;
        host.wbyte(d, a);
        `CHK(a, e)
    endtask
    task automatic rb(input logic ack, input logic [7:0] e);
        logic [7:0] d;
        host.rbyte(ack, d);
        `CHK(d, e)
    endtask
    // four writes from 0x2C run into the top and stay there
    task automatic t_write_sat();
        logic [7:0] ea [4] = '{8'h2C, 8'h2D, 8'h2E, 8'h2E};
        wq_a.delete();
        wq_d.delete();
        host.start();
        wb(8'h98, 1'b0);
        wb(8'h2C, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wb(8'hA0 + i[7:0], 1'b0);
        end
        host.stop();
        `CHK(wq_a.size(), 4)
        for (int i = 0; i < 4; i++) begin
            `CHK(wq_a[i], ea[i])
            `CHK(wq_d[i], 8'hA0 + i[7:0])
        end
    endtask
    // set pointer, repeated start, read three, nack the last
    task automatic t_read();
        wq_a.delete();
        rd_cnt = 0;
        host.start();
        wb(8'h98, 1'b0);
        wb(8'h10, 1'b0);
        host.start();
        wb(8'h99, 1'b0);
        rb(1'b1, 8'h4A);
        rb(1'b1, 8'h4B);
        rb(1'b0, 8'h48);
        `CHK(sda, 1'b1)
        host.stop();
        `CHK(wq_a.size(), 0)
        `CHK(rd_cnt, 3)
    endtask
    // strap high: old address ignored, new one answers
    task automatic t_strap();
        wq_a.delete();
        wq_d.delete();
        strap = 1'b1;
        host.start();
        wb(8'h98, 1'b1);
        wb(8'h05, 1'b1);
        wb(8'h11, 1'b1);
        host.stop();
        host.start();
        wb(8'h9A, 1'b0);
        wb(8'h07, 1'b0);
        wb(8'h33, 1'b0);
        host.stop();
        strap = 1'b0;
        `CHK(wq_a.size(), 1)
        `CHK(wq_a[0], 8'h07)
        `CHK(wq_d[0], 8'h33)
    endtask
    // pointer above the top refused, stored pointer 0x08 kept
    task automatic t_bad_ptr();
        wq_a.delete();
        rd_cnt = 0;
        host.start();
        wb(8'h98, 1'b0);
        wb(8'h2F, 1'b1);
        wb(8'h55, 1'b1);
        host.stop();
        host.start();
        wb(8'h99, 1'b0);
        rb(1'b0, 8'h52);
        host.stop();
        `CHK(wq_a.size(), 0)
        `CHK(rd_cnt, 1)
    endtask
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0] ^ 8'h5A;
        end
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        t_write_sat();
        t_read();
        t_strap();
        t_bad_ptr();
        test_done();
    end
endmodule
